// ==== drt_pkg.sv ====
// constants and types shared by the dual reload timer ends
package drt_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam logic [15:0] SPI_CLK_SEL_OFS = 16'h4240;
	localparam logic [15:0] SPI_RELOAD_OFS = 16'h4242;
	localparam logic [15:0] SPI_COUNT_OFS = 16'h4244;
	localparam logic [15:0] SPI_CTRL_OFS = 16'h4246;
	localparam logic [15:0] TWO_CLK_SEL_OFS = 16'h4260;
	localparam logic [15:0] TWO_RELOAD_OFS = 16'h4262;
	localparam logic [15:0] TWO_COUNT_OFS = 16'h4264;
	localparam logic [15:0] TWO_CTRL_OFS = 16'h4266;
	localparam logic [15:0] CH_MASK = 16'hffcf;
	localparam int RUN_BIT = 0;
	localparam int PRESET_BIT = 1;
	localparam int MODE_BIT = 4;
	localparam int SEL_W = 4;
	localparam int CNT_W = 8;
	localparam int PRE_W = 14;
	localparam logic [3:0] SEL_RESERVED = 4'hf;
	localparam logic [3:0] SEL_RESET = 4'h0;
	localparam logic [7:0] CNT_RESET = 8'hff;
	localparam logic [7:0] RELOAD_RESET = 8'h00;
	localparam logic [7:0] CNT_ZERO = 8'h00;
	localparam logic [7:0] CNT_ONE = 8'h01;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WRITE = 3'b010,
		ST_READ = 3'b100
	} drt_host_st_t;
endpackage : drt_pkg

// ==== drt_bus_if.sv ====
// register bus carrier between the host end and the timer block
`timescale 1ns/100ps
`default_nettype none
interface drt_bus_if;
	logic wr;
	logic rd;
	logic [15:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic rvalid;
	logic [1:0] uflow;
	logic [1:0] xfer_clk;
	modport dev (input wr, rd, addr, wdata,
		output rdata, rvalid, uflow, xfer_clk);
	modport host (output wr, rd, addr, wdata,
		input rdata, rvalid, uflow, xfer_clk);
endinterface : drt_bus_if
`default_nettype wire

// ==== drt_channel.sv ====
// one 8-bit reload timer channel with its own divider tap
`timescale 1ns/100ps
`default_nettype none
module drt_channel #(
	parameter int CNT_W = drt_pkg::CNT_W
) (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic [drt_pkg::PRE_W-1:0] pre_cnt_i,
	input wire logic pre_wrap_i,
	input wire logic [3:0] clock_divider_select_i,
	input wire logic [CNT_W-1:0] reload_value_i,
	input wire logic count_mode_select_i,
	input wire logic run_set_i,
	input wire logic run_clr_i,
	input wire logic timer_preset_strobe_i,
	output logic run_stop_bit_o,
	output logic [CNT_W-1:0] count_o,
	output logic uflow_o,
	output logic xfer_clk_o
);
	logic run_stop_bit_ff, nxt_run_stop_bit;
	logic [CNT_W-1:0] count_ff, nxt_count;
	logic uflow_ff, nxt_uflow;
	logic xfer_clk_ff, nxt_xfer_clk;
	logic tick;

	// tap: low sel bits of the shared prescaler all ones; sel 0 ticks always
	always_comb begin
		tick = 1'b0;
		if (clock_divider_select_i == drt_pkg::SEL_RESET)
			tick = 1'b1;
		else if (clock_divider_select_i != drt_pkg::SEL_RESERVED)
			tick = &(pre_cnt_i | ~((drt_pkg::PRE_W)'((1 << clock_divider_select_i) - 1))) || pre_wrap_i;
	end

	// counting state; preset wins over a coincident tick
	always_comb begin
		nxt_run_stop_bit = run_stop_bit_ff;
		nxt_count = count_ff;
		nxt_uflow = 1'b0;
		nxt_xfer_clk = xfer_clk_ff;
		if (run_set_i)
			nxt_run_stop_bit = 1'b1;
		else if (run_clr_i)
			nxt_run_stop_bit = 1'b0;
		if (timer_preset_strobe_i) begin
			nxt_count = reload_value_i;
		end else if (run_stop_bit_ff && tick) begin
			if (count_ff == drt_pkg::CNT_ZERO) begin
				nxt_count = reload_value_i;
				nxt_uflow = 1'b1;
				nxt_xfer_clk = ~xfer_clk_ff;
				if (count_mode_select_i && !run_set_i)
					nxt_run_stop_bit = 1'b0;
			end else begin
				nxt_count = count_ff - drt_pkg::CNT_ONE;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			run_stop_bit_ff <= 1'b0;
			count_ff <= drt_pkg::CNT_RESET;
			uflow_ff <= 1'b0;
			xfer_clk_ff <= 1'b0;
		end else begin
			run_stop_bit_ff <= nxt_run_stop_bit;
			count_ff <= nxt_count;
			uflow_ff <= nxt_uflow;
			xfer_clk_ff <= nxt_xfer_clk;
		end
	end

	assign run_stop_bit_o = run_stop_bit_ff;
	assign count_o = count_ff;
	assign uflow_o = uflow_ff;
	assign xfer_clk_o = xfer_clk_ff;
endmodule : drt_channel
`default_nettype wire

// ==== drt_timer.sv ====
// device end: register file, shared prescaler and two timer channels
`timescale 1ns/100ps
`default_nettype none
module drt_timer #(
	parameter int NUM_CH = 2
) (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	drt_bus_if.dev bus,
	output logic [1:0] irq_o
);
	// register slots inside one channel's window, one-hot
	localparam int DEC_N = 4;
	localparam int DEC_SEL = 0;
	localparam int DEC_RELOAD = 1;
	localparam int DEC_COUNT = 2;
	localparam int DEC_CTRL = 3;

	// the only address bit in which the two channel windows differ
	localparam logic [15:0] CH_BIT = drt_pkg::TWO_CLK_SEL_OFS
		^ drt_pkg::SPI_CLK_SEL_OFS;

	// shared prescaler
	logic [drt_pkg::PRE_W-1:0] pre_ff, nxt_pre;
	// per-channel software registers
	logic [drt_pkg::CNT_W-1:0] reload_ff [NUM_CH];
	logic [drt_pkg::CNT_W-1:0] nxt_reload [NUM_CH];
	logic [drt_pkg::SEL_W-1:0] sel_ff [NUM_CH];
	logic [drt_pkg::SEL_W-1:0] nxt_sel [NUM_CH];
	logic [NUM_CH-1:0] mode_ff, nxt_mode;
	// one-cycle control strobes towards the channels
	logic [NUM_CH-1:0] run_set, run_clr, preset;
	// channel state seen back from the instances
	logic [NUM_CH-1:0] run_q, uf, xc;
	logic [drt_pkg::CNT_W-1:0] cnt [NUM_CH];
	// registered read port
	logic [15:0] rdata_ff, nxt_rdata;
	logic rvalid_ff, nxt_rvalid;
	// address split into channel and slot
	logic [15:0] local_addr;
	logic sel_hi;
	logic [DEC_N-1:0] wr_hit, rd_hit;

	// register window of one channel, as software sees it:
	//   clock select  - divider tap, low four bits, rest read zero
	//   reload value  - low eight bits, rest read zero
	//   counter       - live count, read-only, writes fall through
	//   control       - run, preset strobe and count mode
	// the second channel repeats the same window one address bit higher;
	// everything else in the decoded range reads zero and ignores writes

	// map a channel-local address onto its register slot; write decode and
	// read mux share it so a slot can never be writable but read as zero
	function automatic logic [DEC_N-1:0] slot_decode(input logic [15:0] a);
		logic [DEC_N-1:0] hit;
		hit = '0;
		case (a)
			drt_pkg::SPI_CLK_SEL_OFS: hit[DEC_SEL] = 1'b1;
			drt_pkg::SPI_RELOAD_OFS: hit[DEC_RELOAD] = 1'b1;
			drt_pkg::SPI_COUNT_OFS: hit[DEC_COUNT] = 1'b1;
			drt_pkg::SPI_CTRL_OFS: hit[DEC_CTRL] = 1'b1;
			default: hit = '0;
		endcase
		return hit;
	endfunction : slot_decode

	// fold the second window onto the first; the folded bit picks the
	// channel, so both channels decode through one table
	assign local_addr = bus.addr & ~CH_BIT;
	assign sel_hi = |(bus.addr & CH_BIT);

	// free-running prescaler from reset; every tap is decoded per channel,
	// so both count clocks stay in phase with each other
	always_comb begin
		nxt_pre = pre_ff + (drt_pkg::PRE_W)'(1);
	end

	// prescaler register only
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			pre_ff <= '0;
		end else begin
			pre_ff <= nxt_pre;
		end
	end

	// software register writes; the counter slot is read-only and a write
	// to it falls through untouched
	always_comb begin
		wr_hit = slot_decode(local_addr);
		for (int i = 0; i < NUM_CH; i++) begin
			nxt_reload[i] = reload_ff[i];
			nxt_sel[i] = sel_ff[i];
			nxt_mode[i] = mode_ff[i];
			if (bus.wr && (sel_hi == (i == 1))) begin
				if (wr_hit[DEC_SEL])
					nxt_sel[i] = bus.wdata[drt_pkg::SEL_W-1:0];
				if (wr_hit[DEC_RELOAD])
					nxt_reload[i] = bus.wdata[drt_pkg::CNT_W-1:0];
				if (wr_hit[DEC_CTRL])
					nxt_mode[i] = bus.wdata[drt_pkg::MODE_BIT];
			end
		end
	end

	// software registers; mode resets to repeat, select to divide-by-one
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			mode_ff <= '0;
			for (int i = 0; i < NUM_CH; i++) begin
				reload_ff[i] <= drt_pkg::RELOAD_RESET;
				sel_ff[i] <= drt_pkg::SEL_RESET;
			end
		end else begin
			mode_ff <= nxt_mode;
			for (int i = 0; i < NUM_CH; i++) begin
				reload_ff[i] <= nxt_reload[i];
				sel_ff[i] <= nxt_sel[i];
			end
		end
	end

	// control strobes live for the single cycle of the write; run and stop
	// come from one bit, so every control write restates the run state
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			run_set[i] = 1'b0;
			run_clr[i] = 1'b0;
			preset[i] = 1'b0;
			if (bus.wr && (sel_hi == (i == 1)) && wr_hit[DEC_CTRL]) begin
				run_set[i] = bus.wdata[drt_pkg::RUN_BIT];
				run_clr[i] = !bus.wdata[drt_pkg::RUN_BIT];
				preset[i] = bus.wdata[drt_pkg::PRESET_BIT];
			end
		end
	end

	// read port: one cycle of latency, data and valid registered together;
	// unmapped slots and reserved bits read zero, the preset bit never reads
	always_comb begin
		rd_hit = slot_decode(local_addr);
		nxt_rvalid = bus.rd;
		nxt_rdata = 16'h0000;
		if (bus.rd) begin
			if (rd_hit[DEC_SEL])
				nxt_rdata = {12'h000, sel_ff[sel_hi]};
			if (rd_hit[DEC_RELOAD])
				nxt_rdata = {8'h00, reload_ff[sel_hi]};
			if (rd_hit[DEC_COUNT])
				nxt_rdata = {8'h00, cnt[sel_hi]};
			if (rd_hit[DEC_CTRL])
				nxt_rdata = {11'h000, mode_ff[sel_hi], 3'h0, run_q[sel_hi]};
		end
	end

	// read port registers only
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			rdata_ff <= 16'h0000;
			rvalid_ff <= 1'b0;
		end else begin
			rdata_ff <= nxt_rdata;
			rvalid_ff <= nxt_rvalid;
		end
	end

	// one channel per instance; ch0 feeds spi, ch1 two-wire
	for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
		drt_channel u_ch (
			.sys_clk_i(sys_clk_i),
			.reset_i(reset_i),
			.pre_cnt_i(pre_ff),
			.pre_wrap_i(1'b0),
			.clock_divider_select_i(sel_ff[g]),
			.reload_value_i(reload_ff[g]),
			.count_mode_select_i(mode_ff[g]),
			.run_set_i(run_set[g]),
			.run_clr_i(run_clr[g]),
			.timer_preset_strobe_i(preset[g]),
			.run_stop_bit_o(run_q[g]),
			.count_o(cnt[g]),
			.uflow_o(uf[g]),
			.xfer_clk_o(xc[g])
		);
	end

	assign bus.rdata = rdata_ff;
	assign bus.rvalid = rvalid_ff;
	assign bus.uflow = uf;
	assign bus.xfer_clk = xc;
	assign irq_o = uf;
endmodule : drt_timer
`default_nettype wire

// ==== drt_host.sv ====
// far end: sequences register accesses for software-side commands
`timescale 1ns/100ps
`default_nettype none
module drt_host (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic cmd_valid_i,
	input wire logic cmd_write_i,
	input wire logic [15:0] cmd_addr_i,
	input wire logic [15:0] cmd_wdata_i,
	output logic cmd_ready_o,
	output logic [15:0] rsp_data_o,
	output logic rsp_valid_o,
	output logic [1:0] uflow_seen_o,
	drt_bus_if.host bus
);
	drt_pkg::drt_host_st_t st_ff, nxt_st;
	logic wr_ff, nxt_wr, rd_ff, nxt_rd;
	logic [15:0] addr_ff, nxt_addr, wdata_ff, nxt_wdata;
	logic [15:0] rsp_ff, nxt_rsp;
	logic rsp_v_ff, nxt_rsp_v;
	logic [1:0] uf_ff;

	// one access at a time; the ordering of setup steps is the user's job
	always_comb begin
		nxt_st = st_ff;
		nxt_wr = 1'b0;
		nxt_rd = 1'b0;
		nxt_addr = addr_ff;
		nxt_wdata = wdata_ff;
		nxt_rsp = rsp_ff;
		nxt_rsp_v = 1'b0;
		case (st_ff)
			drt_pkg::ST_IDLE: if (cmd_valid_i) begin
				nxt_addr = cmd_addr_i;
				nxt_wdata = cmd_wdata_i;
				nxt_wr = cmd_write_i;
				nxt_rd = !cmd_write_i;
				nxt_st = cmd_write_i ? drt_pkg::ST_WRITE : drt_pkg::ST_READ;
			end
			drt_pkg::ST_WRITE: nxt_st = drt_pkg::ST_IDLE;
			drt_pkg::ST_READ: if (bus.rvalid) begin
				nxt_rsp = bus.rdata;
				nxt_rsp_v = 1'b1;
				nxt_st = drt_pkg::ST_IDLE;
			end
			default: nxt_st = drt_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			st_ff <= drt_pkg::ST_IDLE;
			wr_ff <= 1'b0;
			rd_ff <= 1'b0;
			addr_ff <= 16'h0000;
			wdata_ff <= 16'h0000;
			rsp_ff <= 16'h0000;
			rsp_v_ff <= 1'b0;
			uf_ff <= 2'h0;
		end else begin
			st_ff <= nxt_st;
			wr_ff <= nxt_wr;
			rd_ff <= nxt_rd;
			addr_ff <= nxt_addr;
			wdata_ff <= nxt_wdata;
			rsp_ff <= nxt_rsp;
			rsp_v_ff <= nxt_rsp_v;
			uf_ff <= bus.uflow; // registered copy of underflow pulses
		end
	end

	assign bus.wr = wr_ff;
	assign bus.rd = rd_ff;
	assign bus.addr = addr_ff;
	assign bus.wdata = wdata_ff;
	assign cmd_ready_o = st_ff == drt_pkg::ST_IDLE;
	assign rsp_data_o = rsp_ff;
	assign rsp_valid_o = rsp_v_ff;
	assign uflow_seen_o = uf_ff;
endmodule : drt_host
`default_nettype wire

// ==== drt_checker.sv ====
// assertions on the carrier between the host end and the timer end
`timescale 1ns/100ps
`default_nettype none
module drt_checker (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic wr,
	input wire logic rd,
	input wire logic [15:0] addr,
	input wire logic [15:0] wdata,
	input wire logic [15:0] rdata,
	input wire logic rvalid,
	input wire logic [1:0] uflow,
	input wire logic [1:0] xfer_clk
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	// a read is answered on the very next cycle, never later
	a_read_answer: assert property (rd |=> rvalid)
		else $error("read not answered next cycle");
	// preset bit and reserved control bits read back as zero
	a_ctrl_reserved: assert property (rvalid && ($past(addr)
		& drt_pkg::CH_MASK) == drt_pkg::SPI_CTRL_OFS
		|-> (rdata & 16'hffee) == 16'h0000)
		else $error("control readback has stray bits");
	a_sel_reserved: assert property (rvalid && ($past(addr)
		& drt_pkg::CH_MASK) == drt_pkg::SPI_CLK_SEL_OFS
		|-> rdata[15:4] == 12'h000)
		else $error("clock select readback too wide");
	a_reload_width: assert property (rvalid && ($past(addr)
		& drt_pkg::CH_MASK) == drt_pkg::SPI_RELOAD_OFS
		|-> rdata[15:8] == 8'h00)
		else $error("reload readback too wide");
	// anything outside the eight words reads as zero
	a_unmapped_zero: assert property (rvalid && ($past(addr)
		& 16'hffd9) != 16'h4240 |-> rdata == 16'h0000)
		else $error("unmapped read not zero");
	// transfer clocks move only around an underflow pulse
	a_xfer_spi: assert property ($changed(xfer_clk[0]) == uflow[0])
		else $error("spi transfer clock out of step with underflow");
	a_xfer_two: assert property ($changed(xfer_clk[1]) == uflow[1])
		else $error("two-wire transfer clock out of step with underflow");
	// a stop lets at most the pipeline drain, then four cycles of silence
	a_stop_quiet: assert property (wr && !wdata[0]
		&& addr == drt_pkg::SPI_CTRL_OFS
		|-> ##3 (!uflow[0]) [*4])
		else $error("underflow while stopped");
endmodule : drt_checker
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench: host end drives the timer end over the carrier
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic sys_clk_i, reset_i, cmd_valid, cmd_write, cmd_ready, rsp_valid;
	logic [15:0] cmd_addr, cmd_wdata, rsp_data, v, w;
	logic [1:0] irq, seen;
	int err_count, checked, cycles, n;
	drt_bus_if drt_bus_if_i ();
	drt_timer drt_timer_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.bus(drt_bus_if_i), .irq_o(irq));
	drt_host drt_host_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write),
		.cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata),
		.cmd_ready_o(cmd_ready), .rsp_data_o(rsp_data),
		.rsp_valid_o(rsp_valid), .uflow_seen_o(seen), .bus(drt_bus_if_i));
	drt_checker drt_checker_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.wr(drt_bus_if_i.wr), .rd(drt_bus_if_i.rd),
		.addr(drt_bus_if_i.addr), .wdata(drt_bus_if_i.wdata),
		.rdata(drt_bus_if_i.rdata), .rvalid(drt_bus_if_i.rvalid),
		.uflow(drt_bus_if_i.uflow), .xfer_clk(drt_bus_if_i.xfer_clk));
	// free-running clock, 8 ns period
	initial begin
		sys_clk_i = 1'b0;
		forever #4 sys_clk_i = ~sys_clk_i;
	end
	task test_done();
		if (err_count == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : test_done
	// hang guard, well above the few hundred cycles needed
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			test_done();
		end
	end
	task chk(input logic [15:0] s, input logic [15:0] e);
		checked++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	// one host command; valid held until the edge that takes it
	task cmd(input logic wrt, input logic [15:0] a, input logic [15:0] d);
		cmd_valid <= 1'b1;
		cmd_write <= wrt;
		cmd_addr <= a;
		cmd_wdata <= d;
		@(posedge sys_clk_i iff cmd_ready === 1'b1);
		cmd_valid <= 1'b0;
		if (!wrt) begin
			@(posedge sys_clk_i iff rsp_valid === 1'b1);
			v = rsp_data;
		end else begin
			@(posedge sys_clk_i); // valid stays low for one edge
		end
	endtask : cmd
	task rdc(input logic [15:0] a, input logic [15:0] e);
		cmd(1'b0, a, 16'h0000);
		chk(v, e);
	endtask : rdc
	// cycles between two underflow pulses, plus the clock toggle
	task per(input int ch, input logic [15:0] e);
		@(negedge sys_clk_i iff irq[ch] === 1'b1);
		w = {15'h0000, drt_bus_if_i.xfer_clk[ch]};
		n = 0;
		do begin
			@(negedge sys_clk_i);
			n++;
		end while (irq[ch] !== 1'b1);
		chk(16'(n), e);
		chk({15'h0000, drt_bus_if_i.xfer_clk[ch]}, ~w & 16'h0001);
		chk({15'h0000, drt_bus_if_i.uflow[ch]}, 16'h0001);
		@(negedge sys_clk_i);
		chk({15'h0000, irq[ch]}, 16'h0000);
		chk({15'h0000, seen[ch]}, 16'h0001);
		@(posedge sys_clk_i);
	endtask : per
	task t_defaults();
		rdc(drt_pkg::SPI_CLK_SEL_OFS, 16'h0000);
		rdc(drt_pkg::TWO_CTRL_OFS, 16'h0000);
		rdc(drt_pkg::SPI_COUNT_OFS, 16'h00ff);
		rdc(16'h4250, 16'h0000);
	endtask : t_defaults
	task t_repeat();
		cmd(1'b1, drt_pkg::SPI_RELOAD_OFS, 16'h0003);
		cmd(1'b1, drt_pkg::SPI_CTRL_OFS, 16'h0002);
		cmd(1'b1, drt_pkg::SPI_CTRL_OFS, 16'h0001);
		per(0, 16'd4);
		per(0, 16'd4);
		cmd(1'b1, drt_pkg::TWO_CLK_SEL_OFS, 16'h0002);
		cmd(1'b1, drt_pkg::TWO_RELOAD_OFS, 16'h0002);
		cmd(1'b1, drt_pkg::TWO_CTRL_OFS, 16'h0003);
		per(1, 16'd12);
	endtask : t_repeat
	task t_hold();
		cmd(1'b1, drt_pkg::SPI_CTRL_OFS, 16'h0000);
		cmd(1'b0, drt_pkg::SPI_COUNT_OFS, 16'h0000);
		w = v;
		repeat (9) @(posedge sys_clk_i);
		rdc(drt_pkg::SPI_COUNT_OFS, w);
		cmd(1'b1, drt_pkg::SPI_CTRL_OFS, 16'h0002);
		rdc(drt_pkg::SPI_COUNT_OFS, 16'h0003);
	endtask : t_hold
	// one-shot: exactly one pulse, run cleared, counter preset
	task t_oneshot();
		cmd(1'b1, drt_pkg::SPI_CTRL_OFS, 16'h0010);
		cmd(1'b1, drt_pkg::SPI_CTRL_OFS, 16'h0013);
		n = 0;
		repeat (40) begin
			@(negedge sys_clk_i);
			if (irq[0] === 1'b1) n++;
		end
		@(posedge sys_clk_i);
		chk(16'(n), 16'd1);
		rdc(drt_pkg::SPI_CTRL_OFS, 16'h0010);
		rdc(drt_pkg::SPI_COUNT_OFS, 16'h0003);
	endtask : t_oneshot
	// reserved clock select: channel runs but never counts
	task t_reserved();
		cmd(1'b1, drt_pkg::TWO_CTRL_OFS, 16'h0000);
		cmd(1'b1, drt_pkg::TWO_CLK_SEL_OFS, 16'h000f);
		cmd(1'b1, drt_pkg::TWO_CTRL_OFS, 16'h0003);
		repeat (20) @(posedge sys_clk_i);
		rdc(drt_pkg::TWO_COUNT_OFS, 16'h0002);
		rdc(drt_pkg::TWO_CTRL_OFS, 16'h0001);
		rdc(drt_pkg::TWO_CLK_SEL_OFS, 16'h000f);
	endtask : t_reserved
	initial begin
		reset_i = 1'b1;
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_addr = 16'h0000;
		cmd_wdata = 16'h0000;
		repeat (16) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		@(posedge sys_clk_i);
		t_defaults();
		t_repeat();
		t_hold();
		t_oneshot();
		t_reserved();
		test_done();
	end
endmodule : testbench
`default_nettype wire
